/* File: design/fspc_pkg.sv */
// Package of constants and types for the flash self-program controller
package fspc_pkg;

  // Register byte addresses on APB
  localparam logic [11:0] FSPC_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] FSPC_KEY_ADDR    = 12'h004;
  localparam logic [11:0] FSPC_PAGE_ADDR   = 12'h008;
  localparam logic [11:0] FSPC_TADDR_ADDR  = 12'h00c;
  localparam logic [11:0] FSPC_TDATA_ADDR  = 12'h010;
  localparam logic [11:0] FSPC_TCMD_ADDR   = 12'h014;
  localparam logic [11:0] FSPC_STAT_ADDR   = 12'h018;

  // Control register field positions
  localparam int FSPC_TRIG_BIT  = 15;
  localparam int FSPC_EN_BIT    = 14;
  localparam int FSPC_ERR_BIT   = 13;
  localparam int FSPC_ERASE_BIT = 6;
  localparam int FSPC_OP_MSB    = 3;

  // Control register implemented-bit mask and reset value
  localparam logic [15:0] FSPC_CTRL_MASK  = 16'he04f;
  localparam logic [15:0] FSPC_CTRL_RESET = 16'h0000;

  // Unlock key values
  localparam logic [7:0] FSPC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FSPC_KEY_SECOND = 8'haa;

  // Operation codes
  localparam logic [3:0] FSPC_OP_BULK   = 4'hf;
  localparam logic [3:0] FSPC_OP_GENSEG = 4'hd;
  localparam logic [3:0] FSPC_OP_SECSEG = 4'hc;
  localparam logic [3:0] FSPC_OP_WORD   = 4'h3;
  localparam logic [3:0] FSPC_OP_PAGE   = 4'h2;
  localparam logic [3:0] FSPC_OP_ROW    = 4'h1;
  localparam logic [3:0] FSPC_OP_CFG    = 4'h0;

  // Array geometry
  localparam int FSPC_ROW_WORDS  = 64;
  localparam int FSPC_PAGE_WORDS = 512;
  localparam int FSPC_ROW_BYTES  = 192;
  localparam int FSPC_PAGE_BYTES = 1536;

  // Oscillator timing
  localparam int FSPC_OSC_KHZ      = 7370;
  localparam int FSPC_PCLK_KHZ     = 25000;
  localparam int FSPC_ROW_OSC_CYC  = 11064;

  // Table command field positions
  localparam int FSPC_TCMD_HIGH = 0;
  localparam int FSPC_TCMD_BYTE = 1;
  localparam int FSPC_TCMD_READ = 2;

  // Kind of array operation decoded from control bits
  typedef enum logic [2:0] {
    FSPC_K_NONE, FSPC_K_BULK, FSPC_K_SEG, FSPC_K_PAGE, FSPC_K_WORD, FSPC_K_ROW, FSPC_K_CFG
  } fspc_kind_e;

  // Request from the controller to the array
  typedef struct packed {
    logic       start;
    fspc_kind_e kind;
    logic [23:0] addr;
  } fspc_op_s;

endpackage

/* File: design/fspc_osc_div.sv */
// Fractional divider giving one-cycle oscillator tick enables
module fspc_osc_div #(
  parameter int OSC_KHZ  = 7370,
  parameter int PCLK_KHZ = 25000
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Tuning trim
  input  wire logic [5:0] osc_tune,
  // Tick out
  output logic            osc_tick
);

  // Accumulator of the phase
  logic [16:0] acc_reg;
  // Step per pclk with tune applied as a signed trim
  logic [16:0] step;
  logic [16:0] sum;

  // Nominal step plus a small signed tune trim
  always_comb
  begin
    step = 17'(OSC_KHZ) + {{11{osc_tune[5]}}, osc_tune};
    sum  = acc_reg + step;
  end

  // Phase accumulation, tick on wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg  <= '0;
      osc_tick <= 1'b0;
    end
    else if (sum >= 17'(PCLK_KHZ))
    begin
      acc_reg  <= sum - 17'(PCLK_KHZ);
      osc_tick <= 1'b1;
    end
    else
    begin
      acc_reg  <= sum;
      osc_tick <= 1'b0;
    end
  end

endmodule

/* File: design/fspc_op_timer.sv */
// Self-timed operation counter driven by oscillator ticks
module fspc_op_timer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Tick and request
  input  wire logic       osc_tick,
  input  wire logic       start,
  input  wire logic [15:0] length,
  // Status
  output logic            busy,
  output logic            done
);

  // Remaining oscillator cycles
  logic [15:0] cnt_reg;

  // Load on start, count ticks, pulse done at zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_reg <= length;
        busy    <= 1'b1;
      end
      else if (busy && osc_tick)
      begin
        if (cnt_reg <= 16'h0001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

endmodule

/* File: design/fspc_ctrl.sv */
// Flash self-program controller: registers, key, holding buffer, sequencer
// Notes on behaviour
// - Address is page register over effective address
// - Low access covers bits 15..0, byte/word
// - High access covers bits 23..16, byte/word
// - Rows 64 words, pages eight rows
// - Pages and rows aligned from memory start
// - 64-word holding buffer loaded at the slot that the effective address selects
// - Table writes only fill the buffer
// - Processor stalled while operation runs
// - Operations timed in oscillator cycles
// - Trigger starts operation, cleared on completion
// - Key write-only, reads zero
// - Enable bit gates all operations
// - Error flag marks improper sequence
// - Erase bit selects erase or program
// - Erase code decoding
// - Program code decoding
// - Unlisted codes do no operation
// - Control bits cleared only by power-on
// - Unimplemented control bits read zero
// - Trigger is set-only by software
module fspc_ctrl #(
  parameter int ROW_CYC   = 11064,
  parameter int WORD_CYC  = 400,
  parameter int PAGE_CYC  = 12000,
  parameter int BULK_CYC  = 40000,
  parameter int BUF_WORDS = 64
) (
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator trim
  input  wire logic [5:0]  osc_tune,
  // Processor stall and array command
  output logic             cpu_stall,
  output fspc_pkg::fspc_op_s array_op,
  output logic [23:0]      prog_word
);
  import fspc_pkg::*;

  // Control register fields
  logic        trig_reg;
  logic        en_reg;
  logic        err_reg;
  logic        erase_reg;
  logic [3:0]  op_reg;
  // Key progress: 0 none, 1 first seen, 2 both seen
  logic [1:0]  key_state_reg;
  // Page select and effective address
  logic [7:0]  program_page_select_reg;
  logic [15:0] effective_addr_reg;
  // Read-back of last table read
  logic [15:0] tread_reg;
  // Holding buffer
  logic [23:0] hold_mem [BUF_WORDS];
  // Latched operation target
  logic [23:0] op_addr_reg;
  // Bus strobes
  logic        wr_en;
  logic        ctrl_wr;   // Control write taken while no operation runs
  logic [15:0] wdata;
  // Control fields as they stand after this cycle's write
  logic        erase_eff;
  logic [3:0]  op_eff;
  // Timer links
  logic        osc_tick;
  logic        tmr_busy;
  logic        tmr_done;
  logic        launch;
  fspc_kind_e  kind;
  logic [15:0] length;
  logic [23:0] full_addr;
  logic [5:0]  buf_idx;

  // Decode of erase bit and code into an operation kind
  function automatic fspc_kind_e decode_op(input logic erase, input logic [3:0] op);
    fspc_kind_e k;
    k = FSPC_K_NONE;
    if (erase)
    begin
      case (op)
        FSPC_OP_BULK:   k = FSPC_K_BULK;
        FSPC_OP_GENSEG: k = FSPC_K_SEG;
        FSPC_OP_SECSEG: k = FSPC_K_SEG;
        FSPC_OP_PAGE:   k = FSPC_K_PAGE;
        FSPC_OP_CFG:    k = FSPC_K_CFG;
        default:        k = FSPC_K_NONE;
      endcase
    end
    else
    begin
      case (op)
        FSPC_OP_WORD:   k = FSPC_K_WORD;
        FSPC_OP_ROW:    k = FSPC_K_ROW;
        FSPC_OP_CFG:    k = FSPC_K_CFG;
        default:        k = FSPC_K_NONE;
      endcase
    end
    return k;
  endfunction

  // Zero-wait APB, never an error
  // Reads are prepared in the setup cycle so that prdata already stands
  // in the access cycle, when the master takes it
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite && (pstrb[1:0] != 2'b00);
  assign wdata   = pwdata[15:0];
  assign ctrl_wr = wr_en && (paddr == FSPC_CTRL_ADDR) && !trig_reg;

  // Target address and buffer slot
  assign full_addr = {program_page_select_reg, effective_addr_reg};
  assign buf_idx   = effective_addr_reg[6:1];

  // Operation decode and its length in oscillator cycles
  // A trigger write may carry its own erase select and code, so the decode
  // looks at the fields this write is about to store, not the old ones
  always_comb
  begin
    erase_eff = ctrl_wr ? wdata[FSPC_ERASE_BIT] : erase_reg;
    op_eff    = ctrl_wr ? wdata[FSPC_OP_MSB:0] : op_reg;
    kind      = decode_op(erase_eff, op_eff);
    case (kind)
      FSPC_K_ROW:  length = 16'(ROW_CYC);
      FSPC_K_WORD: length = 16'(WORD_CYC);
      FSPC_K_CFG:  length = 16'(WORD_CYC);
      FSPC_K_PAGE: length = 16'(PAGE_CYC);
      default:     length = 16'(BULK_CYC);
    endcase
  end

  // Legal trigger: right after the key pair with enable set
  // A refused attempt made while no operation runs is flagged by the error logic below
  assign launch = wr_en && (paddr == FSPC_CTRL_ADDR) && wdata[FSPC_TRIG_BIT]
                  && !trig_reg && (key_state_reg == 2'd2)
                  && wdata[FSPC_EN_BIT] && (kind != FSPC_K_NONE);

  // Oscillator tick source
  // Ticks stand for oscillator cycles; the tune trim shifts their rate
  fspc_osc_div #(
    .OSC_KHZ  (FSPC_OSC_KHZ),
    .PCLK_KHZ (FSPC_PCLK_KHZ)
  ) u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .osc_tune (osc_tune),
    .osc_tick (osc_tick)
  );

  // Self-timed counter
  // Kept on the power-on reset: the trigger bit survives other resets, and a
  // counter cleared under it would never signal completion
  fspc_op_timer u_tmr (
    .pclk     (pclk),
    .presetn  (por_n),
    .osc_tick (osc_tick),
    .start    (launch),
    .length   (length),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  // Trigger bit: set-only by software, cleared by completion
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      trig_reg <= 1'b0;
    else if (launch)
      trig_reg <= 1'b1;
    else if (tmr_done)
      trig_reg <= 1'b0;
  end

  // Enable, erase select and code fields, held while busy
  // so that the running operation keeps the code it was started with
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      en_reg    <= 1'b0;
      erase_reg <= 1'b0;
      op_reg    <= '0;
    end
    else if (ctrl_wr)
    begin
      en_reg    <= wdata[FSPC_EN_BIT];
      erase_reg <= wdata[FSPC_ERASE_BIT];
      op_reg    <= wdata[FSPC_OP_MSB:0];
    end
  end

  // Error flag: set on bad trigger attempt, software may clear, set wins
  // A refused trigger wins over the flag value that its own write carries
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      err_reg <= 1'b0;
    else if (wr_en && (paddr == FSPC_CTRL_ADDR) && wdata[FSPC_TRIG_BIT]
             && !trig_reg && !launch)
      err_reg <= 1'b1;
    else if (wr_en && (paddr == FSPC_CTRL_ADDR))
      err_reg <= wdata[FSPC_ERR_BIT];
  end

  // Key sequence tracker: any other write breaks it
  // Reads do not break the sequence; only a taken write moves it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_state_reg <= 2'd0;
    else if (wr_en)
    begin
      if (paddr == FSPC_KEY_ADDR && wdata[7:0] == FSPC_KEY_FIRST)
        key_state_reg <= 2'd1;
      else if (paddr == FSPC_KEY_ADDR && wdata[7:0] == FSPC_KEY_SECOND
               && key_state_reg == 2'd1)
        key_state_reg <= 2'd2;
      else
        key_state_reg <= 2'd0;
    end
  end

  // Page select and effective address registers
  // Both sit on the ordinary reset, unlike the control fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_page_select_reg <= '0;
      effective_addr_reg      <= '0;
    end
    else if (wr_en && paddr == FSPC_PAGE_ADDR)
      program_page_select_reg <= wdata[7:0];
    else if (wr_en && paddr == FSPC_TADDR_ADDR)
      effective_addr_reg <= wdata;
  end

  // Table write into the holding buffer only, byte or word wide
  // The buffer has no reset: its contents mean something only once loaded
  always_ff @(posedge pclk)
  begin
    if (wr_en && paddr == FSPC_TCMD_ADDR && !wdata[FSPC_TCMD_READ] && !trig_reg)
    begin
      if (!wdata[FSPC_TCMD_HIGH])
      begin
        if (!wdata[FSPC_TCMD_BYTE])
          hold_mem[buf_idx][15:0] <= pwdata[31:16];
        else if (effective_addr_reg[0])
          hold_mem[buf_idx][15:8] <= pwdata[23:16];
        else
          hold_mem[buf_idx][7:0] <= pwdata[23:16];
      end
      else if (!(wdata[FSPC_TCMD_BYTE] && effective_addr_reg[0]))
        hold_mem[buf_idx][23:16] <= pwdata[23:16];
    end
  end

  // Table read from the holding buffer, phantom byte zero
  // The result is parked in a register read back at its own address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tread_reg <= '0;
    else if (wr_en && paddr == FSPC_TCMD_ADDR && wdata[FSPC_TCMD_READ])
    begin
      if (!wdata[FSPC_TCMD_HIGH])
        tread_reg <= wdata[FSPC_TCMD_BYTE]
          ? {8'h00, effective_addr_reg[0] ? hold_mem[buf_idx][15:8]
                                          : hold_mem[buf_idx][7:0]}
          : hold_mem[buf_idx][15:0];
      else
        tread_reg <= (wdata[FSPC_TCMD_BYTE] && effective_addr_reg[0])
          ? 16'h0000 : {8'h00, hold_mem[buf_idx][23:16]};
    end
  end

  // Latch aligned operation target at launch
  // Word addresses step by two, so a row spans 128 and a page 1024 units
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_addr_reg <= '0;
      array_op    <= '0;
      prog_word   <= '0;
    end
    else
    begin
      array_op.start <= launch;
      if (launch)
      begin
        array_op.kind <= kind;
        case (kind)
          FSPC_K_PAGE: array_op.addr <= full_addr
                         - 24'(full_addr % 24'(FSPC_PAGE_WORDS * 2));
          FSPC_K_ROW:  array_op.addr <= full_addr
                         - 24'(full_addr % 24'(FSPC_ROW_WORDS * 2));
          default:     array_op.addr <= full_addr;
        endcase
        prog_word <= hold_mem[buf_idx];
      end
    end
  end

  // Stall processor while operation runs
  // The trigger bit itself is the stall, so both end on the same edge
  assign cpu_stall = trig_reg;

  // Register read mux, key always reads zero
  // Captured in the setup cycle and held until the next read setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        FSPC_CTRL_ADDR:  prdata <= {16'h0000, FSPC_CTRL_MASK &
                          {trig_reg, en_reg, err_reg, 6'h00, erase_reg, 2'b00, op_reg}};
        FSPC_KEY_ADDR:   prdata <= '0;
        FSPC_PAGE_ADDR:  prdata <= {24'h0, program_page_select_reg};
        FSPC_TADDR_ADDR: prdata <= {16'h0, effective_addr_reg};
        FSPC_TDATA_ADDR: prdata <= {16'h0, tread_reg};
        FSPC_STAT_ADDR:  prdata <= {29'h0, tmr_busy, key_state_reg};
        default:         prdata <= '0;
      endcase
    end
  end

endmodule

/* File: verif/fspc_ctrl_asserts.sv */
// Port-level checker for the flash self-program controller
module fspc_ctrl_asserts (
  // Clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Trim, stall and array command
  input wire logic [5:0]  osc_tune,
  input wire logic        cpu_stall,
  input wire fspc_pkg::fspc_op_s array_op,
  input wire logic [23:0] prog_word
);
  import fspc_pkg::*;

  logic acc;    // Access phase
  logic wr_ctl; // Control write taken
  assign acc = psel && penable;
  assign wr_ctl = acc && pwrite && paddr == FSPC_CTRL_ADDR;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !por_n);

  // Launch and hold of a stall
  sequence s_rise;
    $rose(cpu_stall);
  endsequence
  sequence s_hold;
    cpu_stall [*8];
  endsequence

  a_ready_no_err: assert property (psel |-> pready && !pslverr)
    else $error("bus answer not ready or error");
  a_ctrl_unimpl: assert property (acc && !pwrite && paddr == FSPC_CTRL_ADDR
    |-> (prdata & ~{16'h0000, FSPC_CTRL_MASK}) == 32'h0)
    else $error("unimplemented control bits not zero");
  a_key_reads_zero: assert property (acc && !pwrite && paddr == FSPC_KEY_ADDR
    |-> prdata == 32'h0)
    else $error("key register read not zero");
  a_start_pulse: assert property (array_op.start |=> !array_op.start)
    else $error("start longer than one cycle");
  a_start_stalls: assert property (array_op.start |-> ##[0:1] cpu_stall)
    else $error("launch without stall");
  a_start_kind: assert property (array_op.start |-> array_op.kind != FSPC_K_NONE)
    else $error("launch of an empty operation");
  a_stall_holds: assert property (array_op.start |-> s_hold)
    else $error("stall too short");
  a_stall_ends: assert property (s_rise |-> ##[1:1000] !cpu_stall)
    else $error("stall never ends");
  a_rise_on_ctl: assert property (s_rise |-> $past(wr_ctl) || $past(wr_ctl, 2))
    else $error("stall without control write");
endmodule

bind fspc_ctrl fspc_ctrl_asserts u_chk (.*);

/* File: verif/tb_top.sv */
// Self-checking bench for the flash self-program controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fspc_pkg::*;

  logic        pclk, presetn, por_n;   // Clock and resets
  logic        psel, penable, pwrite;  // APB controls
  logic [11:0] paddr;                  // APB address
  logic [31:0] pwdata, prdata, rdat;   // APB data and last read
  logic [3:0]  pstrb;                  // Byte strobes
  logic        pready, pslverr;        // APB answer
  logic        cpu_stall;              // Processor stall
  logic [5:0]  osc_tune;               // Oscillator trim
  fspc_op_s    array_op;               // Array command
  logic [23:0] prog_word, last_word;   // Program word and capture
  logic [23:0] last_addr;              // Captured target address
  fspc_kind_e  last_kind;              // Captured operation kind
  int          mismatches, num_checks, n_start, run, stall_len;
  // Valid launches and their kinds
  logic [31:0] goods [8] = '{32'h404f, 32'h404d, 32'h404c, 32'h4042,
                             32'h4040, 32'h4003, 32'h4001, 32'h4000};
  fspc_kind_e  kinds [8] = '{FSPC_K_BULK, FSPC_K_SEG, FSPC_K_SEG, FSPC_K_PAGE,
                             FSPC_K_CFG, FSPC_K_WORD, FSPC_K_ROW, FSPC_K_CFG};
  // Codes that must do nothing
  logic [31:0] noops [7] = '{32'h4043, 32'h4041, 32'h400f, 32'h400d,
                             32'h400c, 32'h4002, 32'h4004};

  fspc_ctrl #(.ROW_CYC(20), .WORD_CYC(10), .PAGE_CYC(30), .BULK_CYC(40),
              .BUF_WORDS(64)) u_dut (.*);

  // Clock of 40 ns
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Records launches and stall lengths
  always @(posedge pclk)
  begin
    if (array_op.start === 1'b1)
    begin
      n_start <= n_start + 1;
      last_kind <= array_op.kind;
      last_addr <= array_op.addr;
      last_word <= prog_word;
    end
    if (cpu_stall === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      stall_len <= run;
      run <= 0;
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for pready; only the bench timeout ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // Key pair, then the control value with the trigger bit set
  task automatic launch(input logic [31:0] cmd);
    wr(FSPC_KEY_ADDR, {24'h0, FSPC_KEY_FIRST});
    wr(FSPC_KEY_ADDR, {24'h0, FSPC_KEY_SECOND});
    wr(FSPC_CTRL_ADDR, cmd | (32'h1 << FSPC_TRIG_BIT));
    repeat (2) @(posedge pclk);
  endtask

  // Waits for the stall to drop, bounded by the bench timeout
  task automatic wait_idle();
    while (cpu_stall !== 1'b0)
      @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    int n0;
    {presetn, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    osc_tune = 6'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    rd(FSPC_CTRL_ADDR, 32'h0);
    wr(FSPC_CTRL_ADDR, 32'h7fff);
    rd(FSPC_CTRL_ADDR, 32'h604f);
    wr(FSPC_KEY_ADDR, 32'h55);
    rd(FSPC_KEY_ADDR, 32'h0);
    wr(FSPC_CTRL_ADDR, 32'h0);
    wr(FSPC_CTRL_ADDR, 32'hc001);
    rd(FSPC_CTRL_ADDR, 32'h6001);
    wr(FSPC_CTRL_ADDR, 32'h0);
    launch(32'h8001);
    rd(FSPC_CTRL_ADDR, 32'h2001);
    wr(FSPC_CTRL_ADDR, 32'h0);
    wr(FSPC_KEY_ADDR, 32'h55);
    wr(FSPC_KEY_ADDR, 32'haa);
    wr(FSPC_PAGE_ADDR, 32'h12);
    wr(FSPC_CTRL_ADDR, 32'hc001);
    rd(FSPC_CTRL_ADDR, 32'h6001);
    wr(FSPC_CTRL_ADDR, 32'h0);
    // Fill one holding slot, low word then high byte
    wr(FSPC_TADDR_ADDR, 32'h6);
    wr(FSPC_TCMD_ADDR, 32'hbeef0000);
    wr(FSPC_TCMD_ADDR, 32'h00a50001);
    chk(n_start, 0);
    wr(FSPC_TCMD_ADDR, 32'h4);
    xfer(1'b0, FSPC_TDATA_ADDR, 32'h0);
    chk(rdat[15:0], 16'hbeef);
    wr(FSPC_TCMD_ADDR, 32'h5);
    xfer(1'b0, FSPC_TDATA_ADDR, 32'h0);
    chk(rdat[15:0], 16'h00a5);
    for (int i = 0; i < 8; i++)
    begin
      n0 = n_start;
      launch(goods[i]);
      if (i == 6)
      begin
        wr(FSPC_CTRL_ADDR, 32'h0);
        xfer(1'b0, FSPC_CTRL_ADDR, 32'h0);
        chk(rdat[15], 1'b1);
      end
      wait_idle();
      chk(n_start, n0 + 1);
      chk(last_kind, kinds[i]);
      rd(FSPC_CTRL_ADDR, goods[i]);
      if (i == 5)
      begin
        chk(last_addr, 24'h120006);
        chk(last_word, 24'ha5beef);
      end
      if (i == 3 || i == 6)
        chk(last_addr, 24'h120000);
      if (i == 6)
        chk(stall_len >= 64 && stall_len <= 72, 1'b1);
    end
    foreach (noops[i])
    begin
      n0 = n_start;
      launch(noops[i]);
      wait_idle();
      chk(n_start, n0);
      wr(FSPC_CTRL_ADDR, 32'h0);
    end
    wr(FSPC_CTRL_ADDR, 32'h404f);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(FSPC_CTRL_ADDR, 32'h404f);
    por_n <= 1'b0;
    repeat (3) @(posedge pclk);
    por_n <= 1'b1;
    @(posedge pclk);
    rd(FSPC_CTRL_ADDR, 32'h0);
    wrap_up();
  end
endmodule
